// File: rtl/cesb_charger_event_status_bank.sv
// Charger event flags, event mask, live status and input/sense details.
// Assumes a register port from the serial front end: one-cycle rd/wr strobes,
// read data one cycle later; analog indicators arrive asynchronously.
//
// How it works
// - Flag bit 7 sets when the adaptive-limit status changes.
// - Flag bit 6 sets when the input-valid status changes.
// - Flag bit 5 sets when the current-limit status changes.
// - Flag bit 4 sets when the charger status changes.
// - Flag bit 3 sets when the battery status changes.
// - Flag bit 1 sets when the disconnect status changes.
// - Flag bit 0 sets when the bypass status changes.
// - Reading the flag register returns the flags, then clears them.
// - Mask bit 1 hides its event, 0 passes it; all reset to 1.
// - Adaptive-limit status is 0 while limiting, 1 otherwise.
// - Input-valid status is 1 only when input detail code is 3.
// - Current-limit status clears after 30 ms at limit, sets when below.
// - Battery status is 1 only for battery codes 3, 4 or 7.
// - Bypass status is 0 for any nonzero bypass code, else 1.
// - Input detail code 3 means valid input; 0 to 2 invalid.
// - Sense detail: 0 both connected, 1 plus open, 2 minus, 3 both.
`timescale 1ns/1ps
`default_nettype none

module cesb_charger_event_status_bank #(
	parameter int LIMIT_CYCLES = cesb_pkg::LIM_CYC
) (
	input wire logic i_core_clk,                        // Core clock, 50 MHz
	input wire logic i_rst_b,                           // Async reset, active low
	input wire cesb_pkg::cesb_raw_type i_raw,           // Analog indicators
	input wire cesb_pkg::cesb_reg_req_type i_reg_req,   // Register request
	output logic [7:0] o_reg_rdata,                     // Read data
	output logic o_reg_rvalid,                          // Read data valid
	output logic o_irq                                  // Summary interrupt
);
	import cesb_pkg::*;

	localparam int CNT_W = $clog2(LIMIT_CYCLES + 1);
	localparam logic [CNT_W-1:0] LIM_TOP = CNT_W'(LIMIT_CYCLES);

	cesb_raw_type raw_s;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] flags_q;
	logic [7:0] status_diff;
	logic [7:0] flag_set;
	logic [7:0] mask_q;
	logic [7:0] details;
	logic [7:0] rd_mux;
	logic [CNT_W-1:0] lim_cnt_q;
	logic rd_flags;
	logic wr_mask;

	// ==========================================================
	// Helpers
	function automatic logic bat_is_ok(input logic [2:0] code);
		bat_is_ok = (code == BATTERY_HEALTHY_CODE_A) || (code == BATTERY_HEALTHY_CODE_B) ||
			(code == BATTERY_HEALTHY_CODE_C);
	endfunction : bat_is_ok

	function automatic logic any_unmasked(input logic [7:0] flags, input logic [7:0] mask);
		any_unmasked = |(flags & ~mask & EVENT_BITS);
	endfunction : any_unmasked

	// ==========================================================
	// Indicator synchroniser
	cesb_sync3 #(
		.W($bits(cesb_raw_type)),
		.RST_VAL(RAW_RESET)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_async(i_raw),
		.o_level(raw_s)
	);

	// ==========================================================
	// Current-limit dwell counter; saturates so a long limit stays seen
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			lim_cnt_q <= '0;
		else if (!raw_s.at_current_limit)
			lim_cnt_q <= '0;
		else if (lim_cnt_q != LIM_TOP)
			lim_cnt_q <= lim_cnt_q + CNT_W'(1);
	end

	// ==========================================================
	// Live status decode
	always_comb
	begin
		status_d = '0;
		status_d[BIT_ADAPT] = ~raw_s.adaptive_input_current_limiting;
		status_d[BIT_INPUT] = (raw_s.input_detail_code == INPUT_VALID_CODE);
		status_d[BIT_CURLIM] = ~(raw_s.at_current_limit && (lim_cnt_q == LIM_TOP));
		status_d[BIT_CHARGER] = raw_s.charger_healthy;
		status_d[BIT_BATTERY] = bat_is_ok(raw_s.battery_detail_code);
		status_d[BIT_DISCONNECT] = raw_s.disconnect_state;
		status_d[BIT_BYPASS] = (raw_s.bypass_detail_code == BYPASS_NODE_HEALTHY_CODE);
	end

	// Registered so the flag logic compares against a stable copy
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			status_q <= STATUS_RESET;
		else
			status_q <= status_d;
	end

	// ==========================================================
	// Detail register; codes pass straight from the analog front end
	always_comb
	begin
		details = '0;
		details[DTL_INPUT_LSB +: 2] = raw_s.input_detail_code;
		details[DTL_SENSE_LSB +: 2] = raw_s.sense_line_detail_code;
	end

	// ==========================================================
	// Register port decode
	assign rd_flags = i_reg_req.rd && (i_reg_req.addr == ADDR_EVENT_FLAGS);
	assign wr_mask = i_reg_req.wr && (i_reg_req.addr == ADDR_EVENT_MASK);

	// Status edges seen at the next clock
	assign status_diff = status_d ^ status_q;

	// Change detect per event position; bit 2 is spare and never sets
	always_comb
	begin
		flag_set = '0;
		flag_set[BIT_ADAPT] = status_diff[BIT_ADAPT];
		flag_set[BIT_INPUT] = status_diff[BIT_INPUT];
		flag_set[BIT_CURLIM] = status_diff[BIT_CURLIM];
		flag_set[BIT_CHARGER] = status_diff[BIT_CHARGER];
		flag_set[BIT_BATTERY] = status_diff[BIT_BATTERY];
		flag_set[BIT_DISCONNECT] = status_diff[BIT_DISCONNECT];
		flag_set[BIT_BYPASS] = status_diff[BIT_BYPASS];
	end

	// Change flags; a change in the read cycle survives the clear
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			flags_q <= '0;
		else
			flags_q <= (rd_flags ? 8'h00 : flags_q) | flag_set;
	end

	// Event mask, all masked after reset
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			mask_q <= MASK_RESET;
		else if (wr_mask)
			mask_q <= i_reg_req.wdata;
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb
	begin
		unique case (i_reg_req.addr)
			ADDR_EVENT_FLAGS: rd_mux = flags_q;
			ADDR_EVENT_MASK: rd_mux = mask_q;
			ADDR_LIVE_STATUS: rd_mux = status_q;
			ADDR_INPUT_SENSE: rd_mux = details;
			default: rd_mux = '0;
		endcase
	end

	// Read data from a flop, one cycle after the strobe
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_reg_rdata <= '0;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_req.rd;
			if (i_reg_req.rd)
				o_reg_rdata <= rd_mux;
		end
	end

	// ==========================================================
	// Summary interrupt, level, gated by the mask
	assign o_irq = any_unmasked(flags_q, mask_q);

	// ==========================================================
	// Checks
	property p_flag_sets;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		((status_q ^ $past(status_q)) & EVENT_BITS) != 8'h00
		|-> (((status_q ^ $past(status_q)) & EVENT_BITS) & ~flags_q) == 8'h00;
	endproperty
	a_flag_sets: assert property (p_flag_sets)
		else $error("status change did not set its flag");

	property p_read_clears;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(rd_flags && (status_d == status_q))
		|=> (flags_q == 8'h00) && o_reg_rvalid && (o_reg_rdata == $past(flags_q));
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("flag read did not return and clear flags");

	property p_masked_quiet;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		((mask_q & EVENT_BITS) == EVENT_BITS) |-> !o_irq;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet)
		else $error("interrupt raised with every event masked");

	property p_mask_write;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(wr_mask && (flags_q != 8'h00) && !rd_flags)
		|=> (mask_q == $past(i_reg_req.wdata))
			&& (o_irq == any_unmasked($past(flags_q) | $past(flag_set),
				$past(i_reg_req.wdata)));
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write did not gate interrupt");

	property p_adapt;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(raw_s.adaptive_input_current_limiting)
		|=> status_q[BIT_ADAPT] == !$past(raw_s.adaptive_input_current_limiting);
	endproperty
	a_adapt: assert property (p_adapt)
		else $error("adaptive limit status wrong");

	property p_input_valid;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		##1 (status_q[BIT_INPUT] == ($past(raw_s.input_detail_code) == INPUT_VALID_CODE));
	endproperty
	a_input_valid: assert property (p_input_valid)
		else $error("input valid status wrong");

	property p_limit_dwell;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(raw_s.at_current_limit && (lim_cnt_q == LIM_TOP - CNT_W'(1)))
		##1 raw_s.at_current_limit |=> !status_q[BIT_CURLIM];
	endproperty
	a_limit_dwell: assert property (p_limit_dwell)
		else $error("current limit status not cleared after dwell");

	property p_limit_release;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		!raw_s.at_current_limit |=> status_q[BIT_CURLIM] && (lim_cnt_q == '0);
	endproperty
	a_limit_release: assert property (p_limit_release)
		else $error("current limit status not set below limit");

	property p_battery;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(raw_s.battery_detail_code)
		|=> status_q[BIT_BATTERY] == bat_is_ok($past(raw_s.battery_detail_code));
	endproperty
	a_battery: assert property (p_battery)
		else $error("battery status wrong");

	property p_bypass;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(raw_s.bypass_detail_code != BYPASS_NODE_HEALTHY_CODE) |=> !status_q[BIT_BYPASS];
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass status not low on nonzero code");

	property p_input_flag;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(status_q[BIT_INPUT]) |-> flags_q[BIT_INPUT];
	endproperty
	a_input_flag: assert property (p_input_flag)
		else $error("input valid change did not set its flag");

	property p_curlim_flag;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(status_q[BIT_CURLIM]) |-> flags_q[BIT_CURLIM];
	endproperty
	a_curlim_flag: assert property (p_curlim_flag)
		else $error("current limit change did not set its flag");

	property p_charger;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(raw_s.charger_healthy)
		|=> status_q[BIT_CHARGER] == $past(raw_s.charger_healthy);
	endproperty
	a_charger: assert property (p_charger)
		else $error("charger status wrong");

	property p_battery_flag;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(status_q[BIT_BATTERY]) |-> flags_q[BIT_BATTERY];
	endproperty
	a_battery_flag: assert property (p_battery_flag)
		else $error("battery change did not set its flag");

	property p_disconnect;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(raw_s.disconnect_state)
		|=> status_q[BIT_DISCONNECT] == $past(raw_s.disconnect_state);
	endproperty
	a_disconnect: assert property (p_disconnect)
		else $error("disconnect status wrong");

	property p_bypass_flag;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$changed(status_q[BIT_BYPASS]) |-> flags_q[BIT_BYPASS];
	endproperty
	a_bypass_flag: assert property (p_bypass_flag)
		else $error("bypass change did not set its flag");

	property p_details;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_reg_req.rd && (i_reg_req.addr == ADDR_INPUT_SENSE))
		|=> o_reg_rvalid
			&& (o_reg_rdata[DTL_INPUT_LSB +: 2] == $past(raw_s.input_detail_code))
			&& (o_reg_rdata[DTL_SENSE_LSB +: 2] == $past(raw_s.sense_line_detail_code));
	endproperty
	a_details: assert property (p_details)
		else $error("detail register read wrong");

endmodule : cesb_charger_event_status_bank

`default_nettype wire

// File: rtl/cesb_pkg.sv
// Constants, register map and carriers of the charger event and status bank.
// Assumes one 50 MHz core clock; nothing else is shared with other blocks.
`default_nettype none

package cesb_pkg;

	// ==========================================================
	// Register offsets on the register port
	localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_EVENT_MASK = 8'h11;
	localparam logic [7:0] ADDR_LIVE_STATUS = 8'h12;
	localparam logic [7:0] ADDR_INPUT_SENSE = 8'h13;

	// ==========================================================
	// Bit positions shared by the flag, mask and status registers
	localparam int BIT_ADAPT = 7;
	localparam int BIT_INPUT = 6;
	localparam int BIT_CURLIM = 5;
	localparam int BIT_CHARGER = 4;
	localparam int BIT_BATTERY = 3;
	localparam int BIT_DISCONNECT = 1;
	localparam int BIT_BYPASS = 0;

	// Positions that carry events; bit 2 is spare
	localparam logic [7:0] EVENT_BITS = 8'hfb;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] STATUS_RESET = 8'hbb;

	// ==========================================================
	// Detail register layout
	localparam int DTL_INPUT_LSB = 5;
	localparam int DTL_SENSE_LSB = 1;

	// ==========================================================
	// Detail code decodes
	localparam logic [1:0] INPUT_VALID_CODE = 2'h3;
	localparam logic [2:0] BATTERY_HEALTHY_CODE_A = 3'h3;
	localparam logic [2:0] BATTERY_HEALTHY_CODE_B = 3'h4;
	localparam logic [2:0] BATTERY_HEALTHY_CODE_C = 3'h7;
	localparam logic [3:0] BYPASS_NODE_HEALTHY_CODE = 4'h0;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int LIM_TIME_MS = 30;
	// Least time, exact at this rate so no rounding is lost
	localparam int LIM_CYC = (CLK_HZ / 1000) * LIM_TIME_MS;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic adaptive_input_current_limiting;
		logic [1:0] input_detail_code;
		logic at_current_limit;
		logic charger_healthy;
		logic [2:0] battery_detail_code;
		logic disconnect_state;
		logic [3:0] bypass_detail_code;
		logic [1:0] sense_line_detail_code;
	} cesb_raw_type;

	// Neutral levels held in the synchroniser during reset
	localparam cesb_raw_type RAW_RESET = '{
		adaptive_input_current_limiting: 1'b0,
		input_detail_code: 2'h0,
		at_current_limit: 1'b0,
		charger_healthy: 1'b1,
		battery_detail_code: 3'h3,
		disconnect_state: 1'b1,
		bypass_detail_code: 4'h0,
		sense_line_detail_code: 2'h0
	};

	typedef struct packed {
		logic [7:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} cesb_reg_req_type;

endpackage : cesb_pkg

`default_nettype wire

// File: rtl/cesb_sync3.sv
// Three-stage synchroniser for a vector of slow levels from outside the clock.
// Assumes the levels change far more slowly than the clock.
`timescale 1ns/1ps
`default_nettype none

module cesb_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_core_clk,       // Core clock
	input wire logic i_rst_b,          // Async reset, active low
	input wire logic [W-1:0] i_async,  // Raw levels
	output logic [W-1:0] o_level       // Qualified levels
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// ==========================================================
	// Shift chain; s1 feeds only s2 to keep metastability contained
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end
		else
		begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Per bit, a change counts once stages two and three agree
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_level <= RST_VAL;
		else
			o_level <= (s2_q & ~(s2_q ^ s3_q)) | (o_level & (s2_q ^ s3_q));
	end

endmodule : cesb_sync3

`default_nettype wire

// File: test/cesb_host_model.sv
// Host model: issues reads and writes on the bank's register strobe port.
// Assumes read data comes with a one-cycle valid pulse after the strobe.
`timescale 1ns/1ps
`default_nettype none

module cesb_host_model (
	input wire logic i_core_clk, // Core clock
	input wire logic [7:0] i_reg_rdata, // Read data
	input wire logic i_reg_rvalid, // Read data valid
	output var cesb_pkg::cesb_reg_req_type o_reg_req // Register request
);
	import cesb_pkg::*;

	// ==========================================================
	// Quiet port until the first request
	initial o_reg_req = '{addr: 8'h00, rd: 1'b0, wr: 1'b0, wdata: 8'h00};

	// Read; released fields show inverted values so stale data never matches
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge i_core_clk);
		o_reg_req.addr = a;
		o_reg_req.rd = 1'b1;
		@(negedge i_core_clk);
		o_reg_req.rd = 1'b0;
		o_reg_req.addr = ~a;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (i_reg_rvalid === 1'b1)
			begin
				d = i_reg_rdata;
				ok = 1'b1;
			end
			else
				@(negedge i_core_clk);
		end
	endtask : rd

	// Write; no answer comes back
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge i_core_clk);
		o_reg_req.addr = a;
		o_reg_req.wdata = v;
		o_reg_req.wr = 1'b1;
		@(negedge i_core_clk);
		o_reg_req.wr = 1'b0;
		o_reg_req.addr = ~a;
		o_reg_req.wdata = ~v;
	endtask : wr

endmodule : cesb_host_model

`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the charger event and status bank.
// Assumes the host model drives the register port; short current-limit count.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import cesb_pkg::*;

	// ==========================================================
	// Signals and bench state
	localparam int LIMC = 20;
	logic i_core_clk = 1'b0;
	logic i_rst_b = 1'b0;
	cesb_raw_type raw = RAW_RESET;
	cesb_reg_req_type req;
	logic [7:0] rdata;
	logic rvalid;
	logic irq;
	int err_count = 0;
	int tests_run = 0;
	logic [7:0] st = 8'hbb;
	logic [7:0] fl = 8'h00;
	logic [7:0] msk = 8'hff;
	logic [7:0] d;
	logic lim_long = 1'b0;
	cesb_raw_type r;
	logic [14:0] pats [7] = '{15'h4000, 15'h3000, 15'h0400, 15'h0300, 15'h0040, 15'h0024,
		15'h0002};

	cesb_charger_event_status_bank #(.LIMIT_CYCLES(LIMC)) u_cesb_charger_event_status_bank (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_raw(raw),
		.i_reg_req(req),
		.o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid),
		.o_irq(irq)
	);

	cesb_host_model u_cesb_host_model (
		.i_core_clk(i_core_clk),
		.i_reg_rdata(rdata),
		.i_reg_rvalid(rvalid),
		.o_reg_req(req)
	);

	// 50 MHz clock
	initial forever #10 i_core_clk = ~i_core_clk;

	// ==========================================================
	// Expected live status from the raw levels
	function automatic logic [7:0] exp_st(input cesb_raw_type x);
		logic [7:0] s;
		s = 8'h00;
		s[7] = ~x.adaptive_input_current_limiting;
		s[6] = (x.input_detail_code == 2'h3);
		s[5] = ~lim_long;
		s[4] = x.charger_healthy;
		s[3] = (x.battery_detail_code inside {3'h3, 3'h4, 3'h7});
		s[1] = x.disconnect_state;
		s[0] = (x.bypass_detail_code == 4'h0);
		return s;
	endfunction : exp_st

	// Expected detail register from the raw codes
	function automatic logic [7:0] exp_dtl(input cesb_raw_type x);
		return {1'b0, x.input_detail_code, 2'b00, x.sense_line_detail_code, 1'b0};
	endfunction : exp_dtl

	task automatic final_report();
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	// A lost answer ends the run rather than hanging it
	task automatic reg_rd(input logic [7:0] a);
		bit ok;
		u_cesb_host_model.rd(a, d, ok);
		if (!ok)
		begin
			err_count++;
			final_report();
		end
	endtask : reg_rd

	// Flags collect every status edge since the last flag read
	task automatic upd();
		logic [7:0] n;
		n = exp_st(raw);
		fl = fl | ((st ^ n) & EVENT_BITS);
		st = n;
	endtask : upd

	// Raw change, then enough edges for the synchroniser and status register
	task automatic apply(input cesb_raw_type x);
		@(negedge i_core_clk);
		raw = x;
		repeat (7) @(negedge i_core_clk);
		upd();
	endtask : apply

	task automatic check_all();
		chk({7'h00, |(fl & ~msk & EVENT_BITS)}, {7'h00, irq});
		reg_rd(ADDR_LIVE_STATUS);
		chk(st, d);
		reg_rd(ADDR_EVENT_FLAGS);
		chk(fl, d);
		fl = 8'h00;
		chk(8'h00, {7'h00, irq});
		reg_rd(ADDR_INPUT_SENSE);
		chk(exp_dtl(raw), d);
	endtask : check_all

	// ==========================================================
	// Main sequence
	initial
	begin
		void'($urandom(88));
		repeat (3) @(negedge i_core_clk);
		i_rst_b = 1'b1;
		reg_rd(ADDR_EVENT_MASK);
		chk(8'hff, d);
		check_all();
		$display("test reset done");
		// Each event except current limit alone, plus the sense code, on then off, all unmasked
		msk = 8'h00;
		u_cesb_host_model.wr(ADDR_EVENT_MASK, msk);
		for (int k = 0; k < 14; k++)
		begin
			apply(raw ^ pats[k % 7]);
			check_all();
		end
		check_all();
		$display("test single events done");
		// Read-only places ignore writes, unmapped reads return zero
		u_cesb_host_model.wr(ADDR_LIVE_STATUS, 8'h00);
		u_cesb_host_model.wr(ADDR_EVENT_FLAGS, 8'hff);
		reg_rd(8'h2a);
		chk(8'h00, d);
		check_all();
		$display("test read only done");
		// Current limit must hold its full count before status drops
		r = raw;
		r.at_current_limit = 1'b1;
		apply(r);
		check_all();
		repeat (LIMC) @(negedge i_core_clk);
		lim_long = 1'b1;
		upd();
		check_all();
		r.at_current_limit = 1'b0;
		lim_long = 1'b0;
		apply(r);
		check_all();
		$display("test current limit done");
		// Random levels under random masks
		for (int k = 0; k < 30; k++)
		begin
			r = cesb_raw_type'(15'($urandom));
			r.at_current_limit = 1'b0;
			apply(r);
			// Mask written while flags stand, so the gate is seen to move
			msk = 8'($urandom);
			u_cesb_host_model.wr(ADDR_EVENT_MASK, msk);
			reg_rd(ADDR_EVENT_MASK);
			chk(msk, d);
			check_all();
		end
		$display("test random done");
		final_report();
	end

endmodule : testbench

`default_nettype wire
